// ### amlim_pkg.sv
package amlim_pkg;
   localparam logic [7:0] ADDR_MASK = 8'h06;
   localparam logic [7:0] ADDR_LIMIT = 8'h07;
   localparam logic [15:0] MASK_RESET = 16'h0000;
   localparam logic [15:0] LIMIT_RESET = 16'h0000;
   localparam logic [15:0] MASK_WR_BITS = 16'hFC03;
   localparam int SEL_SHUNT_OVER = 15;
   localparam int SEL_SHUNT_UNDER = 14;
   localparam int SEL_BUS_OVER = 13;
   localparam int SEL_BUS_UNDER = 12;
   localparam int SEL_POWER = 11;
   localparam int SEL_READY = 10;
   localparam int FLAG_HIT = 4;
   localparam int FLAG_READY = 3;
   localparam int FLAG_OVF = 2;
   localparam int CTL_SENSE = 1;
   localparam int CTL_LATCH = 0;

   typedef enum logic [2:0]
   {
      AMLIM_FN_NONE = 3'b000,
      AMLIM_FN_SHUNT_OVER = 3'b001,
      AMLIM_FN_SHUNT_UNDER = 3'b010,
      AMLIM_FN_BUS_OVER = 3'b011,
      AMLIM_FN_BUS_UNDER = 3'b100,
      AMLIM_FN_POWER = 3'b101
   } amlim_func_e;

   typedef struct packed
   {
      logic [15:0] shunt;
      logic [15:0] bus;
      logic [15:0] power;
   } amlim_meas_s;
endpackage

// ### amlim_alert.sv
`timescale 1ns/1ps
module amlim_alert
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   input wire logic conv_done,
   input wire logic math_ovf,
   input wire logic single_shot,
   input wire logic shot_start,
   input wire amlim_pkg::amlim_meas_s meas,
   output logic alert_o,
   output logic alert_oe
);
   import amlim_pkg::*;

   logic [15:0] mask_ctl;
   logic [15:0] limit_value_bits;
   logic limit_hit_flag;
   logic conversion_ready_flag;
   logic math_overflow_flag;
   amlim_meas_s held;
   amlim_func_e func;
   logic cond;
   logic mask_rd;
   logic alert_active;
   logic power_limit_select;
   logic ready_alert_select;
   logic bus_under_select;
   logic alert_sense_invert;
   logic alert_latch_control;

   assign power_limit_select = mask_ctl[SEL_POWER];
   assign ready_alert_select = mask_ctl[SEL_READY];
   assign bus_under_select = mask_ctl[SEL_BUS_UNDER];
   assign alert_sense_invert = mask_ctl[CTL_SENSE];
   assign alert_latch_control = mask_ctl[CTL_LATCH];
   assign mask_rd = reg_rd && (reg_addr == ADDR_MASK);

   // ------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         mask_ctl <= MASK_RESET;
         limit_value_bits <= LIMIT_RESET;
      end
      else if (reg_wr)
      begin
         if (reg_addr == ADDR_MASK)
            mask_ctl <= reg_wdata & MASK_WR_BITS;
         if (reg_addr == ADDR_LIMIT)
            limit_value_bits <= reg_wdata;
      end
   end

   // ------------------------------------------------------------
   // Function select and compare
   // ------------------------------------------------------------
   // highest selection wins
   always_comb
   begin
      if (mask_ctl[SEL_SHUNT_OVER])
         func = AMLIM_FN_SHUNT_OVER;
      else if (mask_ctl[SEL_SHUNT_UNDER])
         func = AMLIM_FN_SHUNT_UNDER;
      else if (mask_ctl[SEL_BUS_OVER])
         func = AMLIM_FN_BUS_OVER;
      else if (bus_under_select)
         func = AMLIM_FN_BUS_UNDER;
      else if (power_limit_select)
         func = AMLIM_FN_POWER;
      else
         func = AMLIM_FN_NONE;
   end

   // Shunt reading is two's complement, bus and power are not
   // compare against threshold
   always_comb
   begin
      unique case (func)
         AMLIM_FN_SHUNT_OVER: cond = $signed(meas.shunt) > $signed(limit_value_bits);
         AMLIM_FN_SHUNT_UNDER: cond = $signed(meas.shunt) < $signed(limit_value_bits);
         AMLIM_FN_BUS_OVER: cond = meas.bus > limit_value_bits;
         AMLIM_FN_BUS_UNDER: cond = meas.bus < limit_value_bits;
         AMLIM_FN_POWER: cond = meas.power > limit_value_bits;
         AMLIM_FN_NONE: cond = 1'b0;
         default: cond = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // Results held from the last completed conversion
   // ------------------------------------------------------------
   // held independent of flag
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         held <= '0;
      else if (conv_done)
         held <= meas;
   end

   // ------------------------------------------------------------
   // Flags
   // ------------------------------------------------------------
   // Setting beats clearing so a hit in the read cycle survives
   // hit flag marks source
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         limit_hit_flag <= 1'b0;
      else if (conv_done && cond)
         limit_hit_flag <= 1'b1;
      else if (alert_latch_control && mask_rd)
         limit_hit_flag <= 1'b0;
      else if (!alert_latch_control && conv_done)
         limit_hit_flag <= 1'b0;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         conversion_ready_flag <= 1'b0;
      else if (conv_done)
         conversion_ready_flag <= 1'b1;
      else if ((single_shot && mask_rd) || shot_start)
         conversion_ready_flag <= 1'b0;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         math_overflow_flag <= 1'b0;
      else if (conv_done && math_ovf)
         math_overflow_flag <= 1'b1;
      // latch holds until read; transparent follows
      else if (alert_latch_control ? mask_rd : conv_done)
         math_overflow_flag <= 1'b0;
   end

   // ------------------------------------------------------------
   // Alert pin
   // ------------------------------------------------------------
   // ready alert joins limit alert
   assign alert_active = limit_hit_flag || (ready_alert_select && conversion_ready_flag);

   // Open collector: only ever pulls low, sense picks when
   // sense select
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         alert_o <= 1'b0;
         alert_oe <= 1'b0;
      end
      else
      begin
         alert_o <= 1'b0;
         alert_oe <= alert_active ^ alert_sense_invert;
      end
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         reg_rdata <= 16'h0000;
      else if (reg_rd)
      begin
         if (reg_addr == ADDR_MASK)
         begin
            reg_rdata <= mask_ctl;
            reg_rdata[FLAG_HIT] <= limit_hit_flag;
            reg_rdata[FLAG_READY] <= conversion_ready_flag;
            reg_rdata[FLAG_OVF] <= math_overflow_flag;
         end
         else if (reg_addr == ADDR_LIMIT)
            reg_rdata <= limit_value_bits;
         else
            reg_rdata <= 16'h0000;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence hit_s;
      conv_done && cond;
   endsequence

   sequence clean_conv_s;
      conv_done && !cond;
   endsequence

   // Bus reading within limit while power may exceed it
   sequence bus_clean_s;
      conv_done && bus_under_select && (mask_ctl[15:13] == 3'b000) && (meas.bus >= limit_value_bits);
   endsequence

   power_hit_a: assert property (hit_s and (func == AMLIM_FN_POWER) |=> limit_hit_flag)
      else $error("power over limit did not raise hit flag");
   latch_read_a: assert property (alert_latch_control && mask_rd && !conv_done |=> !limit_hit_flag)
      else $error("latched hit flag not cleared by read");
   latch_hold_a: assert property (alert_latch_control && limit_hit_flag && !mask_rd |=> limit_hit_flag)
      else $error("latched hit flag dropped without read");
   transp_clear_a: assert property (!alert_latch_control ##0 clean_conv_s |=> !limit_hit_flag)
      else $error("transparent hit flag not cleared by clean conversion");
   ready_set_a: assert property (conv_done |=> conversion_ready_flag)
      else $error("ready flag not set after conversion");
   ready_read_a: assert property (single_shot && mask_rd && !conv_done |=> !conversion_ready_flag)
      else $error("ready flag not cleared by single-shot read");
   ready_start_a: assert property (shot_start && !conv_done |=> !conversion_ready_flag)
      else $error("ready flag not cleared by start");
   ovf_set_a: assert property (conv_done && math_ovf |=> math_overflow_flag)
      else $error("overflow flag not set");
   ready_pin_a: assert property (ready_alert_select && conv_done && !reg_wr |-> ##2 (alert_oe != alert_sense_invert))
      else $error("ready alert did not reach pin");
   sel_prio_a: assert property (!alert_latch_control ##0 bus_clean_s |=> !limit_hit_flag)
      else $error("highest selection did not win");
   held_keep_a: assert property (!conv_done |=> held == $past(held))
      else $error("held results changed without conversion");
   unused_zero_a: assert property (mask_ctl[9:5] == 5'b00000 && mask_ctl[4:2] == 3'b000)
      else $error("unused mask bits not zero");
endmodule

// ### amlim_host.sv
`timescale 1ns/1ps
// Register-side host; idle bus lines carry a changing pattern
module amlim_host
(
   input wire logic mclk,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata
);
   initial
   begin
      reg_addr = 8'hFF;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 16'hA5A5;
   end

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
   begin
      @(posedge mclk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge mclk);
      #1;
      reg_wr = 1'b0;
      reg_wdata = ~d;
      reg_addr = ~a;
   end
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] d);
   begin
      @(posedge mclk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge mclk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   end
   endtask
endmodule

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
   import amlim_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic conv_done = 1'b0;
   logic math_ovf = 1'b0;
   logic single_shot = 1'b0;
   logic shot_start = 1'b0;
   amlim_meas_s meas = '0;
   logic [7:0] reg_addr;
   logic reg_wr;
   logic reg_rd;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic [15:0] v;
   logic alert_o;
   logic alert_oe;
   logic pin;
   int num_errors = 0;
   int num_checks = 0;

   // Pull-up on the open-collector pin
   assign pin = (alert_oe === 1'b1) ? 1'b0 : 1'b1;

   amlim_alert i_amlim_alert (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_done(conv_done), .math_ovf(math_ovf),
      .single_shot(single_shot), .shot_start(shot_start), .meas(meas), .alert_o(alert_o), .alert_oe(alert_oe));
   amlim_host i_amlim_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   initial
   begin
      forever #20 mclk = ~mclk;
   end

   task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
   begin
      num_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", n, exp, seen);
      end
   end
   endtask

   task automatic end_of_test();
   begin
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   end
   endtask

   // Alert output lands two edges after the conversion pulse
   task automatic conv(input logic [15:0] b, input logic [15:0] p, input logic o);
   begin
      @(posedge mclk);
      #1;
      meas.bus = b;
      meas.power = p;
      math_ovf = o;
      conv_done = 1'b1;
      @(posedge mclk);
      #1;
      conv_done = 1'b0;
      math_ovf = 1'b0;
      meas = ~meas;
      @(posedge mclk);
      #1;
   end
   endtask

   // Pin lags the flags by one edge, so let it settle first
   task automatic chk_mask(input logic [15:0] e, input logic p);
   begin
      @(posedge mclk);
      #1;
      chk("pin", {15'h0, pin}, {15'h0, p});
      chk("pin data", {15'h0, alert_o}, 16'h0000);
      i_amlim_host.rd(ADDR_MASK, v);
      chk("mask", v, e);
   end
   endtask

   task automatic t_regs();
   begin
      i_amlim_host.rd(ADDR_MASK, v);
      chk("mask reset", v, 16'h0000);
      i_amlim_host.rd(ADDR_LIMIT, v);
      chk("limit reset", v, 16'h0000);
      i_amlim_host.wr(ADDR_MASK, 16'hFFFF);
      i_amlim_host.rd(ADDR_MASK, v);
      chk("mask bits", v, 16'hFC03);
      i_amlim_host.wr(ADDR_LIMIT, 16'h0100);
      i_amlim_host.rd(ADDR_LIMIT, v);
      chk("limit", v, 16'h0100);
      i_amlim_host.rd(8'h08, v);
      chk("unmapped", v, 16'h0000);
      $display("test regs done");
   end
   endtask

   task automatic t_power();
   begin
      i_amlim_host.wr(ADDR_MASK, 16'h0800);
      conv(16'h0000, 16'h0101, 1'b0);
      chk_mask(16'h0818, 1'b0);
      conv(16'h0000, 16'h0100, 1'b0);
      chk_mask(16'h0808, 1'b1);
      i_amlim_host.wr(ADDR_MASK, 16'h0801);
      conv(16'h0000, 16'hFFFF, 1'b0);
      conv(16'h0000, 16'h0001, 1'b0);
      chk_mask(16'h0819, 1'b0);
      chk_mask(16'h0809, 1'b1);
      $display("test power done");
   end
   endtask

   task automatic t_ready();
   begin
      single_shot = 1'b1;
      i_amlim_host.wr(ADDR_MASK, 16'h0400);
      @(posedge mclk);
      #1;
      shot_start = 1'b1;
      @(posedge mclk);
      #1;
      shot_start = 1'b0;
      @(posedge mclk);
      #1;
      chk_mask(16'h0400, 1'b1);
      conv(16'h0000, 16'h0000, 1'b0);
      chk_mask(16'h0408, 1'b0);
      chk_mask(16'h0400, 1'b1);
      single_shot = 1'b0;
      $display("test ready done");
   end
   endtask

   task automatic t_bus();
   begin
      i_amlim_host.wr(ADDR_MASK, 16'h1802);
      conv(16'h0200, 16'hFFFF, 1'b1);
      chk_mask(16'h180E, 1'b0);
      conv(16'h0050, 16'h0000, 1'b0);
      chk_mask(16'h181A, 1'b1);
      $display("test bus done");
   end
   endtask

   // Negative shunt reading tells a signed compare from an unsigned one
   task automatic t_shunt();
   begin
      i_amlim_host.wr(ADDR_MASK, 16'h8000);
      meas.shunt = 16'hFF00;
      conv(16'h0000, 16'h0000, 1'b0);
      chk_mask(16'h8008, 1'b1);
      i_amlim_host.wr(ADDR_MASK, 16'h2000);
      conv(16'h0200, 16'h0000, 1'b0);
      chk_mask(16'h2018, 1'b0);
      i_amlim_host.wr(ADDR_MASK, 16'h4000);
      meas.shunt = 16'h0200;
      conv(16'h0000, 16'h0000, 1'b0);
      chk_mask(16'h4008, 1'b1);
      meas.shunt = 16'hFF00;
      conv(16'h0000, 16'h0000, 1'b0);
      chk_mask(16'h4018, 1'b0);
      $display("test shunt done");
   end
   endtask

   initial
   begin
      repeat (5000) @(posedge mclk);
      num_errors++;
      end_of_test();
   end

   initial
   begin
      repeat (20) @(posedge mclk);
      #1;
      rst = 1'b0;
      chk("reset pin", {15'h0, pin}, 16'h0001);
      t_regs();
      t_power();
      t_ready();
      t_bus();
      t_shunt();
      end_of_test();
   end
endmodule
